// ---- ovr_fault_resp.sv ----
`timescale 1ns/10ps
// Behaviour
// - byte reaction register, written and read back
// - register governs output over-voltage reaction only
// - top two bits select the reaction
// - code 00 keeps converting on fault
// - code 01 runs for delay, then shuts down and follows retries
// - code 10 shuts down, then follows retries
// - code 11 off while fault present
// - latch cleared by clear events
// - retry field counts restarts; zero means none
// - retry field seven restarts without limit
// - codes one, two allow that many restarts
// - restart attempts spaced by delay setting
// - codes three to six allow that many
// - delay code gives power-of-two unit count
// - fault when output voltage exceeds limit
module ovr_fault_resp #(
  parameter int UNIT_CYCLES = ovr_pkg::UNIT_CYCLES  // shorten in simulation
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_ARST_N,
  input  wire logic [7:0]  I_CMD_CODE,     // bus command code
  input  wire logic        I_WR_BYTE,      // write-byte strobe
  input  wire logic [7:0]  I_WR_DATA,      // write-byte data
  input  wire logic        I_RD_BYTE,      // read-byte strobe
  input  wire logic        I_CLEAR_FAULTS, // clear-faults command pulse
  input  wire logic        I_STATUS_CLR,   // clear of the fault status bit
  input  wire logic        I_ON_CMD,       // control pin and operation: on
  input  wire logic [15:0] I_VOUT,         // measured output voltage
  input  wire logic [15:0] I_OV_LIMIT,     // over-voltage fault limit
  output logic [7:0]       O_RD_DATA,      // read-back byte
  output logic             O_RD_VALID,     // read answer pulse
  output logic             O_OUTPUT_EN,    // power stage enable
  output logic             O_OV_STATUS,    // sticky over-voltage status
  output logic [2:0]       O_STATE         // sequencer state for debug
);
  typedef struct packed {
    ovr_pkg::ovr_state_t st;       // sequencer state
    logic [7:0]          cfg;      // reaction byte
    logic [2:0]          used;     // restart attempts spent
    logic                out_en;   // output enable
    logic                status;   // sticky fault bit
    logic [7:0]          rd_data;  // read-back data
    logic                rd_vld;   // read answer
  } ovr_core_t;

  ovr_core_t c_q;
  ovr_core_t c_d;
  logic      rst_meta;   // first synchroniser stage
  logic      rst_sync;   // reset for the rest of the design
  logic      fault;      // comparator result
  logic      tmr_start;  // start pulse for delay timer
  logic      tmr_done;   // delay expired
  logic      clr_evt;    // any clearing event

  // release reset through two flops; assertion stays asynchronous
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // limit compare; unsigned codes in the same output voltage format
  assign fault   = I_VOUT > I_OV_LIMIT;
  assign clr_evt = I_CLEAR_FAULTS || I_STATUS_CLR;

  // restart allowed while attempts remain, or always for seven
  function automatic logic may_retry(input logic [7:0] cfg,
                                     input logic [2:0] used);
    logic [2:0] lim;
    lim = cfg[ovr_pkg::RETRY_HI:ovr_pkg::RETRY_LO];
    if (lim == ovr_pkg::RETRY_FOREVER) begin
      may_retry = 1'b1;
    end else begin
      may_retry = used < lim;
    end
  endfunction

  ovr_timer #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_timer (
    .i_clk   (I_MCLK),
    .i_rst_n (rst_sync),
    .i_start (tmr_start),
    .i_code  (c_q.cfg[ovr_pkg::DELAY_HI:ovr_pkg::DELAY_LO]),
    .o_done  (tmr_done)
  );

  // register access, status bit and the fault sequencer
  always_comb begin
    c_d        = c_q;
    tmr_start  = 1'b0;
    c_d.rd_vld = 1'b0;
    // byte write and read of the reaction register
    if (I_WR_BYTE && (I_CMD_CODE == ovr_pkg::REG_OV_REACTION)) begin
      c_d.cfg = I_WR_DATA;
    end
    if (I_RD_BYTE) begin
      c_d.rd_vld  = 1'b1;
      // unmapped command codes read as zero
      c_d.rd_data = (I_CMD_CODE == ovr_pkg::REG_OV_REACTION) ?
                    c_q.cfg : 8'h00;
    end
    // status: a fault in the clearing cycle wins over the clear
    if (clr_evt) begin
      c_d.status = 1'b0;
    end
    if (fault) begin
      c_d.status = 1'b1;
    end
    unique case (c_q.st)
      ovr_pkg::OVR_OFF: begin
        c_d.out_en = 1'b0;
        c_d.used   = '0;
        if (I_ON_CMD) begin
          c_d.st     = ovr_pkg::OVR_RUN;
          c_d.out_en = 1'b1;
        end
      end
      ovr_pkg::OVR_RUN: begin
        c_d.used = '0;
        // reaction chosen by the top field on this fault only
        if (fault) begin
          unique case (c_q.cfg[ovr_pkg::RESP_HI:ovr_pkg::RESP_LO])
            ovr_pkg::RESP_IGNORE: begin
              c_d.out_en = 1'b1;
            end
            ovr_pkg::RESP_DELAYED: begin
              c_d.st    = ovr_pkg::OVR_DELAY;
              tmr_start = 1'b1;
            end
            ovr_pkg::RESP_SHUTDOWN: begin
              c_d.out_en = 1'b0;
              if (may_retry(c_q.cfg, c_q.used)) begin
                c_d.st    = ovr_pkg::OVR_WAIT;
                tmr_start = 1'b1;
              end else begin
                c_d.st = ovr_pkg::OVR_LATCH;
              end
            end
            ovr_pkg::RESP_HOLD: begin
              c_d.out_en = 1'b0;
              c_d.st     = ovr_pkg::OVR_HOLD;
            end
          endcase
        end
      end
      ovr_pkg::OVR_DELAY: begin
        // keeps running; only a persisting fault ends in shutdown
        if (!fault) begin
          c_d.st = ovr_pkg::OVR_RUN;
        end else if (tmr_done) begin
          c_d.out_en = 1'b0;
          if (may_retry(c_q.cfg, c_q.used)) begin
            c_d.st    = ovr_pkg::OVR_WAIT;
            tmr_start = 1'b1;
          end else begin
            c_d.st = ovr_pkg::OVR_LATCH;
          end
        end
      end
      ovr_pkg::OVR_WAIT: begin
        if (tmr_done) begin
          c_d.st     = ovr_pkg::OVR_ATTEMPT;
          c_d.out_en = 1'b1;
          tmr_start  = 1'b1;
          // seven never saturates the count, so stop it at six
          if (c_q.used != ovr_pkg::RETRY_FOREVER - 3'h1) begin
            c_d.used = c_q.used + 3'h1;
          end
        end
      end
      ovr_pkg::OVR_ATTEMPT: begin
        // a fault inside the attempt window fails it
        if (fault) begin
          c_d.out_en = 1'b0;
          if (may_retry(c_q.cfg, c_q.used)) begin
            c_d.st    = ovr_pkg::OVR_WAIT;
            tmr_start = 1'b1;
          end else begin
            c_d.st = ovr_pkg::OVR_LATCH;
          end
        end else if (tmr_done) begin
          c_d.st = ovr_pkg::OVR_RUN;
        end
      end
      ovr_pkg::OVR_LATCH: begin
        c_d.out_en = 1'b0;
        if (clr_evt) begin
          c_d.st     = ovr_pkg::OVR_RUN;
          c_d.out_en = 1'b1;
        end
      end
      ovr_pkg::OVR_HOLD: begin
        c_d.out_en = 1'b0;
        if (!fault) begin
          c_d.st     = ovr_pkg::OVR_RUN;
          c_d.out_en = 1'b1;
        end
      end
      default: begin
        c_d.st     = ovr_pkg::OVR_OFF;
        c_d.out_en = 1'b0;
      end
    endcase
    // off command overrides everything; off then on clears a latch
    if (!I_ON_CMD) begin
      c_d.st     = ovr_pkg::OVR_OFF;
      c_d.out_en = 1'b0;
    end
  end

  // state register; reset also stands for loss of bias power
  always_ff @(posedge I_MCLK or negedge rst_sync) begin
    if (!rst_sync) begin
      c_q         <= '0;
      c_q.st      <= ovr_pkg::OVR_OFF;
      c_q.cfg     <= ovr_pkg::REACTION_RST;
    end else begin
      c_q <= c_d;
    end
  end

  assign O_RD_DATA   = c_q.rd_data;
  assign O_RD_VALID  = c_q.rd_vld;
  assign O_OUTPUT_EN = c_q.out_en;
  assign O_OV_STATUS = c_q.status;
  assign O_STATE     = c_q.st;
endmodule // ovr_fault_resp

// ---- ovr_pkg.sv ----
package ovr_pkg;
  // register map and field layout of the reaction byte
  localparam logic [7:0] REG_OV_REACTION = 8'h41;   // reaction byte command
  localparam logic [7:0] REACTION_RST    = 8'h80;   // shut down, no restart
  localparam int         RESP_HI         = 7;       // reaction field top
  localparam int         RESP_LO         = 6;       // reaction field bottom
  localparam int         RETRY_HI        = 5;       // retry field top
  localparam int         RETRY_LO        = 3;       // retry field bottom
  localparam int         DELAY_HI        = 2;       // delay field top
  localparam int         DELAY_LO        = 0;       // delay field bottom
  localparam logic [1:0] RESP_IGNORE     = 2'h0;    // keep converting
  localparam logic [1:0] RESP_DELAYED    = 2'h1;    // run for delay first
  localparam logic [1:0] RESP_SHUTDOWN   = 2'h2;    // off, then retry
  localparam logic [1:0] RESP_HOLD       = 2'h3;    // off while present
  localparam logic [2:0] RETRY_NONE      = 3'h0;    // never restart
  localparam logic [2:0] RETRY_FOREVER   = 3'h7;    // restart without limit
  // timing: one delay unit, in microseconds, at the system clock rate
  localparam int         CLK_MHZ         = 100;     // clock rate
  localparam int         UNIT_US         = 1000;    // default unit length
  localparam int         UNIT_CYCLES     = UNIT_US * CLK_MHZ;
  localparam int         DIV_W           = 24;      // divider counter width
  localparam int         UNITS_W         = 9;       // holds up to 511 units
  // sequencer states
  typedef enum logic [2:0] {
    OVR_OFF,      // commanded off
    OVR_RUN,      // converting normally
    OVR_DELAY,    // fault seen, still running for the delay
    OVR_WAIT,     // output off, waiting to start next attempt
    OVR_ATTEMPT,  // restart attempt in progress
    OVR_LATCH,    // latched off until cleared
    OVR_HOLD      // off while the fault stays present
  } ovr_state_t;
endpackage

// ---- ovr_timer.sv ----
`timescale 1ns/10ps
// counts 2**code delay units after a start pulse, then pulses done
module ovr_timer #(
  parameter int UNIT_CYCLES = ovr_pkg::UNIT_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,   // restarts the count
  input  wire logic [2:0] i_code,    // delay code
  output logic            o_done     // one-cycle pulse at expiry
);
  typedef struct packed {
    logic                         run;    // counting
    logic [ovr_pkg::DIV_W-1:0]    div;    // cycles inside a unit
    logic [ovr_pkg::UNITS_W-1:0]  units;  // whole units elapsed
    logic                         done;   // expiry pulse
  } ovr_tmr_t;

  localparam logic [ovr_pkg::DIV_W-1:0] DIV_LAST =
    ovr_pkg::DIV_W'(UNIT_CYCLES - 1);

  ovr_tmr_t t_q;
  ovr_tmr_t t_d;
  logic     tick;   // unit enable pulse from the divider

  // divider and unit counter
  always_comb begin
    t_d      = t_q;
    t_d.done = 1'b0;
    tick     = t_q.run && (t_q.div == DIV_LAST);
    if (i_start) begin
      t_d.run   = 1'b1;
      t_d.div   = '0;
      t_d.units = '0;
    end else if (t_q.run) begin
      t_d.div = tick ? '0 : t_q.div + 1'b1;
      if (tick) begin
        t_d.units = t_q.units + 1'b1;
        // 1, 2, 4 ... 128 units; at-or-past, so a code lowered
        // by the host in mid-count still expires instead of hanging
        if ((t_q.units + 1'b1) >= (ovr_pkg::UNITS_W'(1) << i_code)) begin
          t_d.run  = 1'b0;
          t_d.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign o_done = t_q.done;
endmodule // ovr_timer

// ---- ovr_host_model.sv ----
`timescale 1ns/10ps
// bus host: moves its lines on the falling edge only
module ovr_host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdat,
  input  wire logic       i_rvld,
  output logic [7:0]      o_cmd,
  output logic            o_wr,
  output logic [7:0]      o_wdat,
  output logic            o_rd
);
  // idle lines at time zero
  initial begin
    o_cmd = 8'h00;
    o_wr = 1'h0;
    o_wdat = 8'h00;
    o_rd = 1'h0;
  end
  // one write strobe; released lines show the inverse
  task automatic wr_b(input logic [7:0] c, input logic [7:0] dt);
    @(negedge i_clk);
    o_cmd = c;
    o_wdat = dt;
    o_wr = 1'h1;
    @(negedge i_clk);
    o_wr = 1'h0;
    o_cmd = ~c;
    o_wdat = ~dt;
  endtask
  // one read strobe; the answer stands for one cycle after the take
  // edge, so it is picked up at the next falling edge, before release
  task automatic rd_b(input logic [7:0] c, output logic [7:0] dt,
                      output logic vl);
    @(negedge i_clk);
    o_cmd = c;
    o_rd = 1'h1;
    @(negedge i_clk);
    dt = i_rdat;
    vl = i_rvld;
    o_rd = 1'h0;
    o_cmd = ~c;
  endtask
endmodule // ovr_host_model

// ---- ovr_fault_resp_monitor.sv ----
`timescale 1ns/10ps
// pin-level watch on the reaction sequencer
module ovr_fault_resp_monitor #(
  parameter int UNIT_CYCLES = ovr_pkg::UNIT_CYCLES
) (
  input wire logic        I_MCLK,
  input wire logic        I_ARST_N,
  input wire logic [7:0]  I_CMD_CODE,
  input wire logic        I_RD_BYTE,
  input wire logic        I_CLEAR_FAULTS,
  input wire logic        I_STATUS_CLR,
  input wire logic        I_ON_CMD,
  input wire logic [15:0] I_VOUT,
  input wire logic [15:0] I_OV_LIMIT,
  input wire logic [7:0]  O_RD_DATA,
  input wire logic        O_RD_VALID,
  input wire logic        O_OUTPUT_EN,
  input wire logic        O_OV_STATUS,
  input wire logic [2:0]  O_STATE
);
  logic        flt;        // live comparator view
  logic [31:0] wait_cnt_q; // cycles spent waiting to retry
  assign flt = I_VOUT > I_OV_LIMIT;
  // counter, since a long wait is too deep for a repetition
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N)
      wait_cnt_q <= 32'h0;
    else if (O_STATE == ovr_pkg::OVR_WAIT)
      wait_cnt_q <= wait_cnt_q + 32'h1;
    else
      wait_cnt_q <= 32'h0;
  end
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);
  sequence s_hold_gone;
    O_STATE == ovr_pkg::OVR_HOLD && !flt && I_ON_CMD;
  endsequence
  sequence s_clr;
    O_STATE == ovr_pkg::OVR_LATCH && I_ON_CMD
      && (I_CLEAR_FAULTS || I_STATUS_CLR);
  endsequence
  sequence s_back_on;
    O_STATE == ovr_pkg::OVR_RUN && O_OUTPUT_EN;
  endsequence
  AST_RD_ANS: assert property (I_RD_BYTE |=> O_RD_VALID)
    else $error("read not answered");
  AST_RD_SRC: assert property (O_RD_VALID |-> $past(I_RD_BYTE))
    else $error("answer without read");
  AST_UNMAP: assert property (O_RD_VALID && $past(I_CMD_CODE) !=
    ovr_pkg::REG_OV_REACTION |-> O_RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  AST_STATUS: assert property (flt |=> O_OV_STATUS)
    else $error("status not set");
  AST_OFF: assert property (!I_ON_CMD |=> !O_OUTPUT_EN)
    else $error("on while commanded off");
  AST_EN_MAP: assert property (O_OUTPUT_EN == (O_STATE inside
    {ovr_pkg::OVR_RUN, ovr_pkg::OVR_DELAY, ovr_pkg::OVR_ATTEMPT}))
    else $error("enable disagrees with state");
  AST_HOLD: assert property (s_hold_gone |=> s_back_on)
    else $error("hold did not resume");
  AST_CLR: assert property (s_clr |=> s_back_on)
    else $error("latch not cleared");
  AST_WAIT: assert property (wait_cnt_q <= 128 * UNIT_CYCLES + 8)
    else $error("retry wait too long");
endmodule // ovr_fault_resp_monitor
bind ovr_fault_resp ovr_fault_resp_monitor #(.UNIT_CYCLES(UNIT_CYCLES))
  mon (.I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_CMD_CODE(I_CMD_CODE),
  .I_RD_BYTE(I_RD_BYTE), .I_CLEAR_FAULTS(I_CLEAR_FAULTS),
  .I_STATUS_CLR(I_STATUS_CLR), .I_ON_CMD(I_ON_CMD), .I_VOUT(I_VOUT),
  .I_OV_LIMIT(I_OV_LIMIT), .O_RD_DATA(O_RD_DATA),
  .O_RD_VALID(O_RD_VALID), .O_OUTPUT_EN(O_OUTPUT_EN),
  .O_OV_STATUS(O_OV_STATUS), .O_STATE(O_STATE));

// ---- ovr_fault_resp_bench.sv ----
`timescale 1ns/10ps
// walks the sequencer through every reaction
module ovr_fault_resp_bench;
  localparam int U = 4; // short unit keeps the run brief
  logic clk = 1'h0, rst_n = 1'h0, on = 1'h0, clrf = 1'h0, sclr = 1'h0;
  logic [15:0] vout = 16'h0, lim = 16'h0;
  logic [7:0]  cmd, wd, rdat, q;
  logic        wr, rd, rvld, en, st, v, pe;
  logic [2:0]  d, sv;
  int n_errors = 0, tests_run = 0, cyc = 0, k, j, n, g, t0;
  ovr_fault_resp #(.UNIT_CYCLES(U)) uut (.I_MCLK(clk), .I_ARST_N(rst_n),
    .I_CMD_CODE(cmd), .I_WR_BYTE(wr), .I_WR_DATA(wd), .I_RD_BYTE(rd),
    .I_CLEAR_FAULTS(clrf), .I_STATUS_CLR(sclr), .I_ON_CMD(on),
    .I_VOUT(vout), .I_OV_LIMIT(lim), .O_RD_DATA(rdat), .O_RD_VALID(rvld),
    .O_OUTPUT_EN(en), .O_OV_STATUS(st), .O_STATE(sv));
  ovr_host_model host (.i_clk(clk), .i_rdat(rdat), .i_rvld(rvld),
    .o_cmd(cmd), .o_wr(wr), .o_wdat(wd), .o_rd(rd));
  initial forever #5 clk = ~clk;
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] gt, input logic [7:0] ex);
    tests_run++;
    if (gt !== ex) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, gt, ex);
    end
  endtask
  task automatic tk(input int c);
    repeat (c) @(negedge clk);
  endtask
  // fault just above the limit, or exactly at it (no fault)
  task automatic flt(input logic f);
    @(negedge clk);
    vout = f ? lim + 16'h1 : lim;
  endtask
  // new reaction byte, then off and on to start clean
  task automatic cfg(input logic [7:0] c);
    flt(1'h0);
    host.wr_b(8'h41, c);
    on = 1'h0;
    tk(3);
    on = 1'h1;
    tk(3);
  endtask
  function automatic int dly(input logic [2:0] c);
    return (1 << c) * U;
  endfunction
  task automatic summarize();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    k = $urandom(32'h55275523);
    lim = 16'($urandom_range(16'hE000, 16'h1000));
    vout = lim;
    tk(12);
    rst_n = 1'h1;
    tk(4);
    host.rd_b(8'h41, q, v);
    chk(q, 8'h80);
    chk(8'(v), 8'h01);
    host.wr_b(8'h42, 8'h5A);
    host.rd_b(8'h42, q, v);
    chk(q, 8'h00);
    chk(8'(v), 8'h01);
    host.rd_b(8'h41, q, v);
    chk(q, 8'h80);
    repeat (6) begin
      k = $urandom;
      host.wr_b(8'h41, k[7:0]);
      host.rd_b(8'h41, q, v);
      chk(q, k[7:0]);
      chk(8'(v), 8'h01);
    end
    cfg({2'h0, 6'($urandom)});
    chk(8'(st), 8'h00);
    flt(1'h1);
    tk(40);
    chk(8'(en), 8'h01);
    chk(8'(st), 8'h01);
    cfg({2'h3, 6'($urandom)});
    flt(1'h1);
    tk(20);
    chk(8'(en), 8'h00);
    chk(8'(sv), 8'(ovr_pkg::OVR_HOLD));
    flt(1'h0);
    tk(3);
    chk(8'(en), 8'h01);
    // latch left by clear-faults, status clear, off-on and a reset
    for (k = 0; k < 4; k++) begin
      cfg({5'h10, 3'($urandom)});
      flt(1'h1);
      tk(2);
      chk(8'(en), 8'h00);
      flt(1'h0);
      tk(60);
      chk(8'(en), 8'h00);
      chk(8'(sv), 8'(ovr_pkg::OVR_LATCH));
      case (k)
        0: clrf = 1'h1;
        1: sclr = 1'h1;
        2: on = 1'h0;
        default: rst_n = 1'h0;
      endcase
      tk(1);
      clrf = 1'h0;
      sclr = 1'h0;
      on = 1'h1;
      rst_n = 1'h1;
      tk(3);
      chk(8'(en), 8'h01);
      if (k != 2)
        chk(8'(st), 8'h00);
    end
    for (k = 1; k < 4; k++) begin
      cfg({5'h08, 3'(k)});
      flt(1'h1);
      tk(dly(3'(k)) - 2);
      chk(8'(en), 8'h01);
      tk(8);
      chk(8'(en), 8'h00);
    end
    for (k = 1; k < 8; k++) begin
      d = 3'($urandom_range(2));
      cfg({2'h2, 3'(k), d});
      flt(1'h1);
      tk(2);
      n = 0;
      pe = 1'h0;
      t0 = 0;
      for (j = 0; j < 10 * (dly(d) + 8); j++) begin
        @(negedge clk);
        if (en === 1'h1 && pe === 1'h0) begin
          n++;
          g = j - t0;
          t0 = j;
        end
        pe = en;
      end
      chk(8'(n > 7 ? 7 : n), 8'(k));
      if (n > 1)
        chk(8'(g >= dly(d) && g <= dly(d) + 6), 8'h01);
    end
    summarize();
  end
endmodule // ovr_fault_resp_bench
